//--- shared/umb_map.vh
// umb_map.vh: register indices, field positions and timing counts for
// the modem status, baud generator and fifo interrupt block.
// assumes the byte address on the bus is four times the register index.
// Functional notes
// - change bits set on input change, cleared on read
// - bits 0,1,3 flag clear-send, set-ready, carrier changes
// - ring change bit only on input rising edge
// - any change bit raises modem status interrupt
// - bits 4-7 show inverted modem input levels
// - loopback maps control bits onto bits 4-7
// - scratchpad at offset 7, stores only
// - generator divides by 1..65535, gives 16x clock
// - latch write reloads the baud counter at once
// - divisor 1, 2 and 3+ waveform shapes, 0 shaped as 3
// - generator input is crystal divided by thirteen
// - receive data interrupt at trigger level
// - line status code 06 beats data code 04
// - data ready high while receive fifo not empty
// - timeout after four idle character times
// - timeout counted in baud clock ticks
// - pending timeout cleared and restarted by read
// - timer restarts on read, or on new character while no timeout pending
// - transmit empty interrupt, cleared by write or ident read
// - single-byte empty indication delayed one character less one bit
// - fifo enable change gives immediate transmit interrupt
// - timeout and trigger share data priority level
// - divisor select bit steers offsets 0 and 1
// - loopback disconnects inputs, loops control outputs
`ifndef UMB_MAP_VH
`define UMB_MAP_VH
`define UMB_IDX_DATA     3'h0
`define UMB_IDX_IEN      3'h1
`define UMB_IDX_IDENT    3'h2
`define UMB_IDX_LCTL     3'h3
`define UMB_IDX_MCTL     3'h4
`define UMB_IDX_LSTAT    3'h5
`define UMB_IDX_MSTAT    3'h6
`define UMB_IDX_SCRATCH  3'h7
`define UMB_LCR_DIVSEL   7
`define UMB_LCR_PAR      3
`define UMB_LCR_STOP     2
`define UMB_MCR_LOOP     4
`define UMB_FCR_EN       0
`define UMB_IIR_NONE     4'h1
`define UMB_IIR_LINE     4'h6
`define UMB_IIR_DATA     4'h4
`define UMB_IIR_TOUT     4'hC
`define UMB_IIR_HOLDING_EMPTY_FLAG     4'h2
`define UMB_IIR_MODEM    4'h0
`define UMB_PRESCALE     4'hD
`define UMB_TICKS_CHAR   5'h10
`define UMB_TOUT_CHARS   3'h4
`endif

//--- hdl/umb_uart_core.v
// umb_uart_core: modem status, scratchpad, baud generator and fifo
// interrupt logic of one serial channel, behind an apb slave.
// assumes the shift paths and fifos live outside and report counts.
`timescale 1ns/1ps
`include "umb_map.vh"
module umb_uart_core (
  // clock and reset
  input  wire        clk_sys,
  input  wire        rst_b,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg         pready,
  output reg  [31:0] prdata,
  output reg         pslverr,
  // modem lines
  input  wire        clear_to_send_in_n,
  input  wire        set_ready_in_n,
  input  wire        ring_in_n,
  input  wire        carrier_in_n,
  output reg         termReadyOutN,
  output reg         request_send_out_n,
  output reg         userOutOneN,
  output reg         userOutTwoN,
  // receive and transmit path status
  input  wire [4:0]  rxCount,
  input  wire        rxCharIn,
  input  wire [4:0]  txCount,
  input  wire        lineErrPend,
  input  wire [7:0]  rxData,
  input  wire [7:0]  lineStatusIn,
  output reg         rxReadPulse,
  output reg         txWritePulse,
  output reg  [7:0]  txWriteData,
  output reg         rxFifoClr,
  output reg         txFifoClr,
  output reg         lineStatRead,
  // generator and interrupt
  output reg         baudOut,
  output reg         baudTick,
  output reg         irqOut
);

  // reset release
  reg        rstMeta_q;
  reg        rstN_q;
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rstMeta_q <= 1'b0;
      rstN_q    <= 1'b0;
    end else begin
      rstMeta_q <= 1'b1;
      rstN_q    <= rstMeta_q;
    end
  end

  // registers
  reg  [3:0]  ien_q;
  reg  [7:0]  lctl_q;
  reg  [4:0]  mctl_q;
  reg  [7:0]  fctl_q;
  reg  [7:0]  scratch_q;
  reg  [7:0]  divLo_q;
  reg  [7:0]  divHi_q;
  reg  [3:0]  msrChg_q;
  reg  [3:0]  lvlPrev_q;
  reg  [3:0]  modemMeta_q;
  reg  [3:0]  modemSync_q;

  // apb decode
  wire        setupPh  = psel & ~penable & ~pready;
  wire        accDone  = psel & penable & pready;
  wire        addrOk   = (paddr[11:5] == 7'h00) & (paddr[1:0] == 2'h0);
  wire [2:0]  idx      = paddr[4:2];
  wire        divSel   = lctl_q[`UMB_LCR_DIVSEL];
  wire        wrAcc    = accDone & pwrite & addrOk;
  wire        rdAcc    = accDone & ~pwrite & addrOk;
  wire        wrData   = wrAcc & (idx == `UMB_IDX_DATA) & ~divSel;
  wire        wrDivLo  = wrAcc & (idx == `UMB_IDX_DATA) & divSel;
  wire        wrDivHi  = wrAcc & (idx == `UMB_IDX_IEN) & divSel;
  wire        wrIen    = wrAcc & (idx == `UMB_IDX_IEN) & ~divSel;
  wire        wrFctl   = wrAcc & (idx == `UMB_IDX_IDENT);
  wire        rdData   = rdAcc & (idx == `UMB_IDX_DATA) & ~divSel;
  wire        rdIdent  = rdAcc & (idx == `UMB_IDX_IDENT);
  wire        rdMstat  = rdAcc & (idx == `UMB_IDX_MSTAT);
  wire        rdLstat  = rdAcc & (idx == `UMB_IDX_LSTAT);

  // modem inputs and loopback
  wire [3:0]  pinsN = {carrier_in_n, ring_in_n, set_ready_in_n,
                       clear_to_send_in_n};
  wire        loopOn = mctl_q[`UMB_MCR_LOOP];
  // status level order: clear-send, set-ready, ring, carrier
  wire [3:0]  lvlNow = loopOn ?
                       {mctl_q[3], mctl_q[2], mctl_q[0], mctl_q[1]} :
                       ~modemSync_q;
  wire [3:0]  chgSeen;
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : gModem
      if (gi == 2) begin : gRing
        // ring input rising means level falling
        assign chgSeen[gi] = lvlPrev_q[gi] & ~lvlNow[gi];
      end else begin : gDelta
        assign chgSeen[gi] = lvlPrev_q[gi] ^ lvlNow[gi];
      end
      always @(posedge clk_sys or negedge rstN_q) begin
        if (!rstN_q) begin
          modemMeta_q[gi] <= 1'b1;
          modemSync_q[gi] <= 1'b1;
          lvlPrev_q[gi]   <= 1'b0;
          msrChg_q[gi]    <= 1'b0;
        end else begin
          modemMeta_q[gi] <= pinsN[gi];
          modemSync_q[gi] <= modemMeta_q[gi];
          lvlPrev_q[gi]   <= lvlNow[gi];
          // set wins over read clear
          msrChg_q[gi]    <= chgSeen[gi] |
                             (msrChg_q[gi] & ~rdMstat);
        end
      end
    end
  endgenerate
  wire        modemPend = |msrChg_q;

  // character length in bits
  wire [3:0]  charBits = 4'h7 + {2'b00, lctl_q[1:0]} +
                         {3'b000, lctl_q[`UMB_LCR_PAR]} +
                         {3'b000, lctl_q[`UMB_LCR_STOP]};

  // baud generator
  reg  [3:0]  preCnt_q;
  reg  [15:0] brgCnt_q;
  wire [15:0] divVal  = {divHi_q, divLo_q};
  wire [15:0] divEff  = (divVal == 16'h0000) ? 16'h0003 : divVal;
  wire        preTick = (preCnt_q == (`UMB_PRESCALE - 4'h1));
  wire        brgWrap = preTick & (brgCnt_q <= 16'h0001);
  wire [15:0] newDiv  = wrDivLo ? {divHi_q, pwdata[7:0]} :
                                  {pwdata[7:0], divLo_q};
  wire [15:0] newEff  = (newDiv == 16'h0000) ? 16'h0003 : newDiv;
  reg         brgLvl;
  always @* begin
    if (divVal == 16'h0001)
      brgLvl = (preCnt_q >= 4'h7);
    else if (divVal == 16'h0002)
      brgLvl = (brgCnt_q == 16'h0001);
    else
      brgLvl = (brgCnt_q < (divEff - 16'h0001));
  end
  always @(posedge clk_sys or negedge rstN_q) begin
    if (!rstN_q) begin
      preCnt_q <= 4'h0;
      brgCnt_q <= 16'h0003;
      baudOut  <= 1'b0;
      baudTick <= 1'b0;
    end else begin
      preCnt_q <= preTick ? 4'h0 : preCnt_q + 4'h1;
      if (wrDivLo | wrDivHi)
        brgCnt_q <= newEff;
      else if (brgWrap)
        brgCnt_q <= divEff;
      else if (preTick)
        brgCnt_q <= brgCnt_q - 16'h0001;
      baudOut  <= brgLvl;
      baudTick <= brgWrap;
    end
  end

  // receive interrupts
  wire        fifoOn = fctl_q[`UMB_FCR_EN];
  reg  [4:0]  trigLvl;
  always @* begin
    case (fctl_q[7:6])
      2'h0:    trigLvl = 5'h01;
      2'h1:    trigLvl = 5'h04;
      2'h2:    trigLvl = 5'h08;
      default: trigLvl = 5'h0E;
    endcase
  end
  wire        rxAvail = fifoOn ? (rxCount >= trigLvl) :
                                 (rxCount != 5'h00);
  reg  [11:0] toutCnt_q;
  reg         toutPend_q;
  wire [11:0] toutLim = {2'b00, charBits, 6'h00};     // four chars of 16
  wire        toutHit = fifoOn & (rxCount != 5'h00) &
                        (toutCnt_q >= toutLim);
  always @(posedge clk_sys or negedge rstN_q) begin
    if (!rstN_q) begin
      toutCnt_q  <= 12'h000;
      toutPend_q <= 1'b0;
    end else begin
      if (rdData | (rxCharIn & ~toutPend_q))
        toutCnt_q <= 12'h000;
      else if (baudTick & ~toutHit)
        toutCnt_q <= toutCnt_q + 12'h001;
      if (rdData)
        toutPend_q <= 1'b0;
      else if (toutHit)
        toutPend_q <= 1'b1;
    end
  end

  // transmit empty interrupt
  reg  [4:0]  txPrev_q;
  reg         multiSeen_q;
  reg         dlyAct_q;
  reg  [11:0] dlyCnt_q;
  reg         threPend_q;
  reg         fifoOnPrev_q;
  wire        txEmptyEdge = (txCount == 5'h00) & (txPrev_q != 5'h00);
  wire        dlyDone     = dlyAct_q & baudTick & (dlyCnt_q <= 12'h001);
  wire        fifoFlip    = fifoOn ^ fifoOnPrev_q;
  wire        threNow     = (txEmptyEdge & ~(fifoOn & ~multiSeen_q)) |
                            dlyDone | (fifoFlip & ien_q[1]);
  wire        threInIdent;
  wire        threClr     = wrData | (rdIdent & threInIdent);
  always @(posedge clk_sys or negedge rstN_q) begin
    if (!rstN_q) begin
      txPrev_q     <= 5'h00;
      multiSeen_q  <= 1'b0;
      dlyAct_q     <= 1'b0;
      dlyCnt_q     <= 12'h000;
      threPend_q   <= 1'b0;
      fifoOnPrev_q <= 1'b0;
    end else begin
      txPrev_q     <= txCount;
      fifoOnPrev_q <= fifoOn;
      if (txCount >= 5'h02)
        multiSeen_q <= 1'b1;
      else if (threNow)
        multiSeen_q <= 1'b0;
      if (txEmptyEdge & fifoOn & ~multiSeen_q) begin
        dlyAct_q <= 1'b1;
        dlyCnt_q <= {4'h0, charBits - 4'h1, 4'h0};
      end else if (dlyDone | wrData) begin
        dlyAct_q <= 1'b0;
      end else if (dlyAct_q & baudTick) begin
        dlyCnt_q <= dlyCnt_q - 12'h001;
      end
      threPend_q <= threNow | (threPend_q & ~threClr);
    end
  end

  // identification priority
  reg  [3:0]  identCode;
  always @* begin
    if (lineErrPend & ien_q[2])
      identCode = `UMB_IIR_LINE;
    else if (ien_q[0] & rxAvail)
      identCode = `UMB_IIR_DATA;
    else if (ien_q[0] & toutPend_q)
      identCode = `UMB_IIR_TOUT;
    else if (ien_q[1] & threPend_q)
      identCode = `UMB_IIR_HOLDING_EMPTY_FLAG;
    else if (ien_q[3] & modemPend)
      identCode = `UMB_IIR_MODEM;
    else
      identCode = `UMB_IIR_NONE;
  end
  assign threInIdent = (identCode == `UMB_IIR_HOLDING_EMPTY_FLAG);

  // read mux
  wire        dataReady = lineStatusIn[0] | (rxCount != 5'h00);
  wire        txEmpty   = (txCount == 5'h00);
  reg  [7:0]  rdByte;
  always @* begin
    case (idx)
      `UMB_IDX_DATA:    rdByte = divSel ? divLo_q : rxData;
      `UMB_IDX_IEN:     rdByte = divSel ? divHi_q : {4'h0, ien_q};
      `UMB_IDX_IDENT:   rdByte = {fifoOn, fifoOn, 2'b00, identCode};
      `UMB_IDX_LCTL:    rdByte = lctl_q;
      `UMB_IDX_MCTL:    rdByte = {3'b000, mctl_q};
      `UMB_IDX_LSTAT:   rdByte = {lineStatusIn[7:6], txEmpty,
                                  lineStatusIn[4:1], dataReady};
      `UMB_IDX_MSTAT:   rdByte = {lvlNow, msrChg_q};
      `UMB_IDX_SCRATCH: rdByte = scratch_q;
      default:          rdByte = 8'h00;
    endcase
  end

  // register writes and bus answer
  always @(posedge clk_sys or negedge rstN_q) begin
    if (!rstN_q) begin
      ien_q        <= 4'h0;
      lctl_q       <= 8'h00;
      mctl_q       <= 5'h00;
      fctl_q       <= 8'h00;
      scratch_q    <= 8'h00;
      divLo_q      <= 8'h00;
      divHi_q      <= 8'h00;
      pready       <= 1'b0;
      prdata       <= 32'h00000000;
      pslverr      <= 1'b0;
      rxReadPulse  <= 1'b0;
      txWritePulse <= 1'b0;
      txWriteData  <= 8'h00;
      rxFifoClr    <= 1'b0;
      txFifoClr    <= 1'b0;
      lineStatRead <= 1'b0;
    end else begin
      pready  <= setupPh;
      if (setupPh) begin
        prdata  <= (addrOk & ~pwrite) ? {24'h000000, rdByte} :
                                        32'h00000000;
        pslverr <= ~addrOk;
      end
      if (wrIen)
        ien_q <= pwdata[3:0];
      if (wrFctl)
        fctl_q <= {pwdata[7:6], 5'h00, pwdata[0]};
      if (wrAcc & (idx == `UMB_IDX_LCTL))
        lctl_q <= pwdata[7:0];
      if (wrAcc & (idx == `UMB_IDX_MCTL))
        mctl_q <= pwdata[4:0];
      if (wrAcc & (idx == `UMB_IDX_SCRATCH))
        scratch_q <= pwdata[7:0];
      if (wrDivLo)
        divLo_q <= pwdata[7:0];
      if (wrDivHi)
        divHi_q <= pwdata[7:0];
      if (wrData)
        txWriteData <= pwdata[7:0];
      txWritePulse <= wrData;
      rxReadPulse  <= rdData;
      rxFifoClr    <= wrFctl & ((pwdata[1] & pwdata[0]) |
                                (pwdata[0] ^ fifoOn));
      txFifoClr    <= wrFctl & ((pwdata[2] & pwdata[0]) |
                                (pwdata[0] ^ fifoOn));
      lineStatRead <= rdLstat;
    end
  end

  // modem outputs and interrupt pin
  always @(posedge clk_sys or negedge rstN_q) begin
    if (!rstN_q) begin
      termReadyOutN      <= 1'b1;
      request_send_out_n <= 1'b1;
      userOutOneN        <= 1'b1;
      userOutTwoN        <= 1'b1;
      irqOut             <= 1'b0;
    end else begin
      // loopback forces the pins inactive
      termReadyOutN      <= ~mctl_q[0] | loopOn;
      request_send_out_n <= ~mctl_q[1] | loopOn;
      userOutOneN        <= ~mctl_q[2] | loopOn;
      userOutTwoN        <= ~mctl_q[3] | loopOn;
      irqOut             <= mctl_q[3] & (identCode != `UMB_IIR_NONE);
    end
  end

endmodule

//--- dv/umb_uart_core_asserts.sv
// umb_uart_core_asserts.sv: port checker for umb_uart_core.
// assumes byte address is index times four; divisor 0 counts as 3.
`timescale 1ns/1ps
module umb_core_chk (
  // clock and reset
  input logic        clk_sys,
  input logic        rst_b,
  // apb
  input logic        psel,
  input logic        penable,
  input logic        pwrite,
  input logic [11:0] paddr,
  input logic [31:0] pwdata,
  input logic        pready,
  input logic [31:0] prdata,
  input logic        pslverr,
  // modem outputs, generator, interrupt
  input logic        termReadyOutN,
  input logic        request_send_out_n,
  input logic        userOutOneN,
  input logic        userOutTwoN,
  input logic        baudTick,
  input logic        irqOut
);
  logic        hit, cmt, lwr, seen_q;
  logic [2:0]  idx;
  logic [7:0]  mcr_q, scr_q, lcr_q, dll_q, dlh_q;
  logic [31:0] gap_q, per;
  assign idx = paddr[4:2];
  assign hit = psel && penable && pready && paddr[11:5] == 7'h00
               && paddr[1:0] == 2'h0;
  assign cmt = hit && pwrite;
  assign lwr = cmt && lcr_q[7] && idx[2:1] == 2'h0;
  // divisor 0 behaves as three counts
  assign per = 32'hD * ({dlh_q, dll_q} == 16'h0 ? 32'h3
                        : {16'h0, dlh_q, dll_q});
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      mcr_q  <= 8'h00;
      scr_q  <= 8'h00;
      lcr_q  <= 8'h00;
      dll_q  <= 8'h00;
      dlh_q  <= 8'h00;
      gap_q  <= 32'h0;
      seen_q <= 1'b0;
    end else begin
      if (cmt && idx == 3'h4) mcr_q <= pwdata[7:0];
      if (cmt && idx == 3'h7) scr_q <= pwdata[7:0];
      if (cmt && idx == 3'h3) lcr_q <= pwdata[7:0];
      if (lwr && !idx[0]) dll_q <= pwdata[7:0];
      if (lwr && idx[0]) dlh_q <= pwdata[7:0];
      gap_q  <= (baudTick || lwr) ? 32'h0 : gap_q + 32'h1;
      seen_q <= !lwr && (seen_q || baudTick);
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  sequence s_setup;
    psel && !penable;
  endsequence
  property p_zero_wait;
    s_setup |=> pready;
  endproperty
  a_zero_wait: assert property (p_zero_wait)
    else $error("no zero-wait answer");
  property p_bad_addr;
    s_setup ##1 (paddr[11:5] != 7'h00 || paddr[1:0] != 2'h0)
      |-> pslverr && pready;
  endproperty
  a_bad_addr: assert property (p_bad_addr)
    else $error("unmapped access not flagged");
  property p_scratch;
    hit && !pwrite && idx == 3'h7 |-> prdata == {24'h0, scr_q};
  endproperty
  a_scratch: assert property (p_scratch)
    else $error("scratch readback wrong");
  property p_divisor;
    hit && !pwrite && lcr_q[7] && idx[2:1] == 2'h0
      |-> prdata == {24'h0, idx[0] ? dlh_q : dll_q};
  endproperty
  a_divisor: assert property (p_divisor)
    else $error("divisor readback wrong");
  property p_loop_out;
    mcr_q[4] && $past(mcr_q[4]) |-> {termReadyOutN, userOutOneN,
      request_send_out_n, userOutTwoN} == 4'hF;
  endproperty
  a_loop_out: assert property (p_loop_out)
    else $error("control pins active in loopback");
  property p_ctl_out;
    !mcr_q[4] && $stable(mcr_q) |-> {userOutTwoN, userOutOneN,
      request_send_out_n, termReadyOutN} == ~mcr_q[3:0];
  endproperty
  a_ctl_out: assert property (p_ctl_out)
    else $error("control pins differ from control bits");
  property p_irq_gate;
    !mcr_q[3] && !$past(mcr_q[3]) |=> !irqOut;
  endproperty
  a_irq_gate: assert property (p_irq_gate)
    else $error("interrupt line not gated");
  property p_baud;
    baudTick && seen_q |-> gap_q == per - 32'h1;
  endproperty
  a_baud: assert property (p_baud)
    else $error("generator period wrong");
endmodule
bind umb_uart_core umb_core_chk u_chk (
  .clk_sys, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
  .prdata, .pslverr, .termReadyOutN, .request_send_out_n, .userOutOneN,
  .userOutTwoN, .baudTick, .irqOut
);

//--- dv/umb_modem_model.sv
// umb_modem_model.sv: far-end modem driving the four status lines.
// assumes the bench sets target levels; lines follow LAG+1 clocks after a change.
`timescale 1ns/1ps
module umb_modem_model #(
  parameter int LAG = 1
) (
  // clock and target levels {carrier, ring, ready, clear}
  input  logic       clk_sys,
  input  logic [3:0] lineCmd,
  // active-low status lines
  output logic       clear_to_send_in_n,
  output logic       set_ready_in_n,
  output logic       ring_in_n,
  output logic       carrier_in_n
);
  logic [3:0] line_q = 4'hF;
  int         wait_q = 0;
  always @(posedge clk_sys) begin
    if (lineCmd == line_q || wait_q >= LAG) wait_q <= 0;
    else wait_q <= wait_q + 1;
    if (wait_q >= LAG) line_q <= lineCmd;
  end
  assign {carrier_in_n, ring_in_n, set_ready_in_n,
          clear_to_send_in_n} = line_q;
endmodule

//--- dv/uart_modem_status_baud_fifo_irq_test.sv
// uart_modem_status_baud_fifo_irq_test.sv: directed bench for the core.
// assumes the modem model and the bound port checker.
`timescale 1ns/1ps
module uart_modem_status_baud_fifo_irq_test;
  logic        clk_sys, rst_b, psel, penable, pwrite;
  logic        pready, pslverr, irqOut, lineErrPend;
  logic        ctsN, dsrN, riN, dcdN;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [4:0]  rxCount;
  logic [3:0]  lineCmd;
  logic [7:0]  rd, e;
  int          failures = 0;
  int          check_count = 0;
  umb_modem_model #(.LAG(3)) u_modem (
    .clk_sys, .lineCmd, .clear_to_send_in_n(ctsN),
    .set_ready_in_n(dsrN), .ring_in_n(riN), .carrier_in_n(dcdN)
  );
  umb_uart_core u_dut (
    .clk_sys, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pready, .prdata, .pslverr, .clear_to_send_in_n(ctsN),
    .set_ready_in_n(dsrN), .ring_in_n(riN), .carrier_in_n(dcdN),
    .termReadyOutN(), .request_send_out_n(), .userOutOneN(),
    .userOutTwoN(), .rxCount, .rxCharIn(1'h0), .txCount(5'h00),
    .lineErrPend, .rxData(8'h3C), .lineStatusIn(8'h00),
    .rxReadPulse(), .txWritePulse(), .txWriteData(), .rxFifoClr(),
    .txFifoClr(), .lineStatRead(), .baudOut(), .baudTick(), .irqOut
  );
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  task tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task chk(input string nm, input logic [7:0] ex, input logic [7:0] got);
    check_count++;
    if (got !== ex) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task acc(input logic w, input logic [3:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= {6'h00, a, 2'h0};
    pwdata <= {24'h0, d};
    @(posedge clk_sys);
    penable <= 1'b1;
    // look at pready between edges, then act on the edge that samples it
    do begin
      @(negedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 20);
    @(posedge clk_sys);
    if (n >= 20) failures++;
    rd = prdata[7:0];
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task rdc(input string nm, input logic [3:0] a, input logic [7:0] ex);
    acc(1'b0, a, 8'h00);
    chk(nm, ex, rd);
  endtask
  task t_scratch;
    acc(1'b1, 4'h7, 8'hA5);
    rdc("scratch", 4'h7, 8'hA5);
    acc(1'b1, 4'h7, 8'h5A);
    rdc("scratch", 4'h7, 8'h5A);
    acc(1'b0, 4'h8, 8'h00);
    chk("unmapped", 8'h01, {7'h00, pslverr});
    $display("scratch done");
  endtask
  task t_modem;
    rdc("msr idle", 4'h6, 8'h00);
    for (int i = 0; i < 4; i++) begin
      lineCmd[i] <= 1'b0;
      tick(16);
      e = {~lineCmd, 4'h0};
      e[i] = (i != 2);
      rdc("msr fall", 4'h6, e);
    end
    lineCmd <= 4'hF;
    tick(16);
    rdc("msr rise", 4'h6, 8'h0F);
    rdc("msr reread", 4'h6, 8'h00);
    $display("modem done");
  endtask
  task t_loop;
    acc(1'b1, 4'h4, 8'h12);
    tick(8);
    acc(1'b0, 4'h6, 8'h00);
    chk("loop rts", 8'h01, {4'h0, rd[7:4]});
    acc(1'b1, 4'h4, 8'h19);
    tick(8);
    acc(1'b0, 4'h6, 8'h00);
    chk("loop dtr", 8'h0A, {4'h0, rd[7:4]});
    lineCmd <= 4'h0;
    tick(16);
    rdc("loop pins", 4'h6, 8'hA0);
    lineCmd <= 4'hF;
    tick(16);
    acc(1'b1, 4'h4, 8'h00);
    tick(8);
    rdc("loop exit", 4'h6, 8'h0A);
    $display("loop done");
  endtask
  task t_baud;
    logic [7:0] dv [4] = '{8'h00, 8'h02, 8'h03, 8'h01};
    acc(1'b1, 4'h3, 8'h80);
    foreach (dv[i]) begin
      acc(1'b1, 4'h0, dv[i]);
      acc(1'b1, 4'h1, 8'h00);
      tick(100);
      rdc("div low", 4'h0, dv[i]);
    end
    rdc("div high", 4'h1, 8'h00);
    acc(1'b1, 4'h3, 8'h00);
    $display("baud done");
  endtask
  task t_holding_empty_flag;
    acc(1'b1, 4'h4, 8'h08);
    acc(1'b1, 4'h1, 8'h02);
    acc(1'b1, 4'h2, 8'h01);
    tick(2);
    rdc("tx empty", 4'h2, 8'hC2);
    chk("irq", 8'h01, {7'h00, irqOut});
    rdc("tx cleared", 4'h2, 8'hC1);
    $display("holding_empty_flag done");
  endtask
  task t_rx;
    acc(1'b1, 4'h2, 8'h41);
    acc(1'b1, 4'h1, 8'h05);
    rxCount <= 5'h03;
    rdc("below trig", 4'h2, 8'hC1);
    rxCount <= 5'h04;
    rdc("at trig", 4'h2, 8'hC4);
    lineErrPend <= 1'b1;
    rdc("line first", 4'h2, 8'hC6);
    lineErrPend <= 1'b0;
    rxCount <= 5'h01;
    rdc("rx data", 4'h0, 8'h3C);
    rdc("lsr ready", 4'h5, 8'h21);
    tick(5000);
    rdc("no timeout", 4'h2, 8'hC1);
    tick(1500);
    rdc("timeout", 4'h2, 8'hCC);
    chk("irq", 8'h01, {7'h00, irqOut});
    rdc("rx data", 4'h0, 8'h3C);
    rdc("tout clear", 4'h2, 8'hC1);
    rxCount <= 5'h00;
    rdc("lsr empty", 4'h5, 8'h20);
    $display("rx done");
  endtask
  task wrap_up;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    #300000;
    failures++;
    wrap_up();
  end
  initial begin
    rst_b       = 1'b0;
    psel        = 1'b0;
    penable     = 1'b0;
    pwrite      = 1'b0;
    paddr       = 12'h000;
    pwdata      = 32'h0;
    rxCount     = 5'h00;
    lineErrPend = 1'b0;
    lineCmd     = 4'hF;
    tick(10);
    rst_b <= 1'b1;
    tick(3);
    t_scratch();
    t_modem();
    t_loop();
    t_baud();
    t_holding_empty_flag();
    t_rx();
    wrap_up();
  end
endmodule
